// ---- rtl/prrc_pkg.sv ----
package prrc_pkg;
  // Command opcodes on the command port
  localparam logic [3:0] CMD_UNLOCK = 4'h1;
  localparam logic [3:0] CMD_FSCALE = 4'h2;
  localparam logic [3:0] CMD_HIGH = 4'h3;
  localparam logic [3:0] CMD_INTEG = 4'h4;
  localparam logic [3:0] CMD_IDLE = 4'h5;
  localparam logic [3:0] CMD_SAVE = 4'h6;
  localparam logic [3:0] CMD_CLRERR = 4'h7;
  // Register read addresses
  localparam logic [3:0] ADDR_FSCALE = 4'h0;
  localparam logic [3:0] ADDR_FSUNIT = 4'h1;
  localparam logic [3:0] ADDR_HIGH = 4'h2;
  localparam logic [3:0] ADDR_INTEG = 4'h3;
  localparam logic [3:0] ADDR_IDLE = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_FSREF = 4'h6;
  localparam logic [3:0] ADDR_TICKCFG = 4'h7;
  // Units that may not carry a custom full scale (not checked: CMD_FSCALE takes any pressure_unit_select_in)
  localparam logic [4:0] UNIT_USER = 5'h0D;
  localparam logic [4:0] UNIT_LOGIC_COMMON = 5'h0E;
  localparam logic [4:0] UNIT_PERCENT_SCALE = 5'h0F;
  // Analog level limits in 50 mV counts
  localparam logic [7:0] HIGH_MAX = 8'h64;
  localparam logic [7:0] HIGH_RESET = 8'h64;
  // Integration limits
  localparam logic [7:0] INTEG_MAX = 8'h78;
  localparam logic [7:0] INTEG_RESET = 8'h02;
  localparam logic INTEG_FORM_RATE = 1'b1;
  localparam logic INTEG_FORM_PERIOD = 1'b0;
  localparam logic [7:0] IDLE_RESET = 8'h00;
  localparam logic [7:0] IDLE_MAX = 8'hFF;
  // Period step 100 ms at 50 MHz
  localparam int CLK_HZ = 50000000;
  localparam int PERIOD_STEP_MS = 100;
  localparam int PERIOD_STEP_CYC = CLK_HZ / 1000 * PERIOD_STEP_MS;
  localparam int STEPS_PER_SEC = 1000 / PERIOD_STEP_MS;
endpackage

// ---- rtl/prrc_top.sv ----
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module prrc_top #(
  parameter int FS_W = 20,
  parameter int STEP_CYC = prrc_pkg::PERIOD_STEP_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // Command port
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_op_in,
  input wire logic [FS_W-1:0] cmd_arg_in,
  input wire logic cmd_form_in,
  // Register read port
  input wire logic rd_in,
  input wire logic [3:0] addr_in,
  output logic [31:0] rdata_out,
  // Context from the rest of the device
  input wire logic [FS_W-1:0] factory_fs_in,
  input wire logic [4:0] pressure_unit_select_in,
  input wire logic [7:0] low_level_in,
  input wire logic watchdog_output_option_in,
  input wire logic speed_shift_first_in,
  input wire logic speed_shift_second_in,
  // Configuration outputs
  output logic [FS_W-1:0] fs_ref_out,
  output logic [7:0] high_level_out,
  output logic integ_tick_out,
  output logic sample_out,
  output logic speed_shift_en_out,
  output logic command_error_flag_out
);
  typedef struct packed {
    logic unlocked;
    logic [FS_W-1:0] fscale;
    logic [4:0] fs_unit;
    logic [7:0] high;
    logic integ_form;
    logic [7:0] integ_val;
    logic saved_form;
    logic [7:0] saved_val;
    logic [7:0] idle;
    logic err;
    logic [31:0] step_cnt;
    logic [7:0] skip_cnt;
    logic tick;
    logic sample;
    logic [31:0] rdata;
  } prrc_state_t;

  prrc_state_t st_r, st_nxt;
  logic [FS_W-1:0] half_fs;
  logic [31:0] tick_len;
  logic wr_ok;
  logic [7:0] arg8;

  assign half_fs = factory_fs_in >> 1;
  assign arg8 = (cmd_arg_in > FS_W'(prrc_pkg::IDLE_MAX)) ? prrc_pkg::IDLE_MAX : cmd_arg_in[7:0];
  assign wr_ok = cmd_valid_in && st_r.unlocked;

  // Rate form: one second of steps split n ways; period form: n steps of 100 ms
  // Both scale with STEP_CYC, so a short step in simulation shortens both forms alike
  always_comb begin
    if (st_r.integ_form == prrc_pkg::INTEG_FORM_RATE) begin
      tick_len = (32'(STEP_CYC) * 32'(prrc_pkg::STEPS_PER_SEC)) / 32'(st_r.integ_val);
    end else begin
      tick_len = 32'(STEP_CYC) * 32'(st_r.integ_val);
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.sample = 1'b0;
    // Tick generator runs first, so an integration command below can restart the period
    if (st_r.step_cnt + 32'h1 >= tick_len) begin
      st_nxt.step_cnt = '0;
      st_nxt.tick = 1'b1;
      if (st_r.integ_form == prrc_pkg::INTEG_FORM_RATE) begin
        st_nxt.sample = 1'b1;
        st_nxt.skip_cnt = '0;
      end else if (st_r.skip_cnt >= st_r.idle) begin
        st_nxt.sample = 1'b1;
        st_nxt.skip_cnt = '0;
      end else begin
        st_nxt.skip_cnt = st_r.skip_cnt + 8'h01;
      end
    end else begin
      st_nxt.step_cnt = st_r.step_cnt + 32'h1;
    end
    // Unlock lasts only until the next command of any kind
    if (cmd_valid_in) begin
      st_nxt.unlocked = (cmd_op_in == prrc_pkg::CMD_UNLOCK);
    end
    if (wr_ok) begin
      case (cmd_op_in)
        prrc_pkg::CMD_FSCALE: begin
          if (cmd_arg_in == '0) begin
            st_nxt.fscale = '0;
          end else if (cmd_arg_in >= half_fs && cmd_arg_in <= factory_fs_in) begin
            st_nxt.fscale = cmd_arg_in;
            st_nxt.fs_unit = pressure_unit_select_in;
          end else begin
            st_nxt.err = 1'b1;
          end
        end
        prrc_pkg::CMD_HIGH: begin
          if (arg8 == 8'h00 || arg8 >= prrc_pkg::HIGH_MAX) begin
            // The clamped value is still refused when it meets the low level
            if (prrc_pkg::HIGH_MAX == low_level_in) st_nxt.err = 1'b1;
            else st_nxt.high = prrc_pkg::HIGH_MAX;
          end else if (arg8 == low_level_in) begin
            st_nxt.err = 1'b1;
          end else begin
            st_nxt.high = arg8;
          end
        end
        prrc_pkg::CMD_INTEG: begin
          if (cmd_arg_in > FS_W'(prrc_pkg::INTEG_MAX)) begin
            st_nxt.err = 1'b1;
          end else if (cmd_arg_in == '0) begin
            st_nxt.integ_form = st_r.saved_form;
            st_nxt.integ_val = st_r.saved_val;
          end else begin
            st_nxt.integ_form = cmd_form_in;
            st_nxt.integ_val = cmd_arg_in[7:0];
          end
          // Restart the period so the new length applies at once
          st_nxt.step_cnt = '0;
        end
        prrc_pkg::CMD_IDLE: begin
          if (cmd_arg_in > FS_W'(prrc_pkg::IDLE_MAX) || (watchdog_output_option_in && cmd_arg_in != '0)) begin
            st_nxt.err = 1'b1;
          end else begin
            st_nxt.idle = cmd_arg_in[7:0];
          end
        end
        prrc_pkg::CMD_SAVE: begin
          st_nxt.saved_form = st_r.integ_form;
          st_nxt.saved_val = st_r.integ_val;
        end
        prrc_pkg::CMD_CLRERR: begin
          st_nxt.err = 1'b0;
        end
        default: begin
        end
      endcase
    end
    st_nxt.rdata = '0;
    if (rd_in) begin
      case (addr_in)
        prrc_pkg::ADDR_FSCALE: st_nxt.rdata = 32'(st_r.fscale);
        prrc_pkg::ADDR_FSUNIT: st_nxt.rdata = 32'(st_r.fs_unit);
        prrc_pkg::ADDR_HIGH: st_nxt.rdata = 32'(st_r.high);
        prrc_pkg::ADDR_INTEG: st_nxt.rdata = {23'h0, st_r.integ_form, st_r.integ_val};
        prrc_pkg::ADDR_IDLE: st_nxt.rdata = 32'(st_r.idle);
        prrc_pkg::ADDR_STATUS: st_nxt.rdata = {31'h0, st_r.err};
        prrc_pkg::ADDR_FSREF: st_nxt.rdata = 32'(fs_ref_out);
        prrc_pkg::ADDR_TICKCFG: st_nxt.rdata = 32'(st_r.skip_cnt);
        default: st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= '0;
      st_r.high <= prrc_pkg::HIGH_RESET;
      st_r.integ_form <= prrc_pkg::INTEG_FORM_PERIOD;
      st_r.integ_val <= prrc_pkg::INTEG_RESET;
      st_r.saved_form <= prrc_pkg::INTEG_FORM_PERIOD;
      st_r.saved_val <= prrc_pkg::INTEG_RESET;
      st_r.idle <= prrc_pkg::IDLE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs, all registered
  logic [FS_W-1:0] fs_ref_r;
  logic spd_r;
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fs_ref_r <= '0;
      spd_r <= 1'b0;
    end else begin
      fs_ref_r <= (st_nxt.fscale != '0) ? st_nxt.fscale : factory_fs_in;
      spd_r <= (st_nxt.integ_form == prrc_pkg::INTEG_FORM_PERIOD) &&
               (speed_shift_first_in || speed_shift_second_in);
    end
  end
  assign fs_ref_out = fs_ref_r;
  assign speed_shift_en_out = spd_r;
  assign high_level_out = st_r.high;
  assign integ_tick_out = st_r.tick;
  assign sample_out = st_r.sample;
  assign command_error_flag_out = st_r.err;
  assign rdata_out = st_r.rdata;

  high_range_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    st_r.high != 8'h00 && st_r.high <= prrc_pkg::HIGH_MAX) else $error("high level out of range");
  high_equal_low_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (wr_ok && cmd_op_in == prrc_pkg::CMD_HIGH && cmd_arg_in[7:0] == low_level_in && cmd_arg_in != '0
     && cmd_arg_in < FS_W'(prrc_pkg::HIGH_MAX)) |=> (st_r.err && $stable(st_r.high))) else $error("equal level accepted");
  locked_ignore_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (cmd_valid_in && !st_r.unlocked && cmd_op_in == prrc_pkg::CMD_HIGH) |=> $stable(st_r.high))
    else $error("locked write took effect");
  fs_window_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    st_r.fscale == '0 || (st_r.fscale >= half_fs && st_r.fscale <= factory_fs_in))
    else $error("full scale outside window");
  idle_wdog_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (wr_ok && cmd_op_in == prrc_pkg::CMD_IDLE && watchdog_output_option_in && cmd_arg_in != '0)
    |=> (st_r.err && $stable(st_r.idle))) else $error("idle count taken under watchdog");
  integ_bad_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (wr_ok && cmd_op_in == prrc_pkg::CMD_INTEG && cmd_arg_in > FS_W'(prrc_pkg::INTEG_MAX))
    |=> (st_r.err && $stable(st_r.integ_val))) else $error("bad integration accepted");
  integ_zero_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (wr_ok && cmd_op_in == prrc_pkg::CMD_INTEG && cmd_arg_in == '0)
    |=> (st_r.integ_val == $past(st_r.saved_val))) else $error("zero did not restore");
  rate_sample_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (st_r.tick && st_r.integ_form == prrc_pkg::INTEG_FORM_RATE && $past(st_r.integ_form)
     == prrc_pkg::INTEG_FORM_RATE) |-> st_r.sample) else $error("rate tick skipped");

  // Setting commands count only when they directly follow an unlock
  sequence unlock_s;
    cmd_valid_in && cmd_op_in == prrc_pkg::CMD_UNLOCK;
  endsequence
  sequence high_plain_s;
    cmd_valid_in && cmd_op_in == prrc_pkg::CMD_HIGH && arg8 != 8'h00 && arg8 < prrc_pkg::HIGH_MAX &&
      arg8 != low_level_in;
  endsequence
  sequence high_clamp_s;
    cmd_valid_in && cmd_op_in == prrc_pkg::CMD_HIGH && (arg8 == 8'h00 || arg8 >= prrc_pkg::HIGH_MAX) &&
      low_level_in != prrc_pkg::HIGH_MAX;
  endsequence
  sequence fs_inside_s;
    cmd_valid_in && cmd_op_in == prrc_pkg::CMD_FSCALE && cmd_arg_in != '0 && cmd_arg_in >= half_fs &&
      cmd_arg_in <= factory_fs_in;
  endsequence
  sequence integ_ok_s;
    cmd_valid_in && cmd_op_in == prrc_pkg::CMD_INTEG && cmd_arg_in != '0 &&
      cmd_arg_in <= FS_W'(prrc_pkg::INTEG_MAX);
  endsequence
  sequence idle_ok_s;
    cmd_valid_in && cmd_op_in == prrc_pkg::CMD_IDLE && cmd_arg_in <= FS_W'(prrc_pkg::IDLE_MAX) &&
      (!watchdog_output_option_in || cmd_arg_in == '0);
  endsequence
  sequence save_s;
    cmd_valid_in && cmd_op_in == prrc_pkg::CMD_SAVE;
  endsequence
  sequence clear_s;
    cmd_valid_in && cmd_op_in == prrc_pkg::CMD_CLRERR;
  endsequence

  high_write_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (unlock_s ##1 high_plain_s) |=> (st_r.high == $past(arg8))) else $error("high level not stored");
  high_clamp_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (unlock_s ##1 high_clamp_s) |=> (st_r.high == prrc_pkg::HIGH_MAX)) else $error("high level not clamped");
  fs_accept_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (unlock_s ##1 fs_inside_s) |=> (st_r.fscale == $past(cmd_arg_in) &&
      st_r.fs_unit == $past(pressure_unit_select_in))) else $error("full scale not taken");
  // Reference follows the custom value whenever one is stored
  fs_ref_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    st_r.fscale != '0 |-> fs_ref_out == st_r.fscale) else $error("custom full scale not used");
  fs_locked_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (cmd_valid_in && !st_r.unlocked && cmd_op_in == prrc_pkg::CMD_FSCALE) |=> $stable(st_r.fscale))
    else $error("locked full scale took effect");
  integ_write_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (unlock_s ##1 integ_ok_s) |=> (FS_W'(st_r.integ_val) == $past(cmd_arg_in) &&
      st_r.integ_form == $past(cmd_form_in))) else $error("integration not stored");
  idle_write_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (unlock_s ##1 idle_ok_s) |=> (FS_W'(st_r.idle) == $past(cmd_arg_in))) else $error("idle count not stored");
  save_copy_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (unlock_s ##1 save_s) |=> (st_r.saved_val == $past(st_r.integ_val) &&
      st_r.saved_form == $past(st_r.integ_form))) else $error("save did not copy integration");
  error_clear_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (unlock_s ##1 clear_s) |=> !st_r.err) else $error("error flag not cleared");
  sample_tick_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    st_r.sample |-> st_r.tick) else $error("sample without integration tick");
  skip_period_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (st_r.tick && !st_r.sample) |-> ($past(st_r.integ_form) == prrc_pkg::INTEG_FORM_PERIOD))
    else $error("cycle skipped in rate form");
  rate_speed_a: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (st_r.integ_form == prrc_pkg::INTEG_FORM_RATE) |-> !speed_shift_en_out) else $error("speed shift in rate form");
endmodule

// ---- sim/prrc_host.sv ----
`timescale 1ns/100ps
module prrc_host #(
  parameter int FS_W = 20
) (
  // Clock
  input wire logic core_clk_in,
  // Command port towards the block
  output logic cmd_valid_out,
  output logic [3:0] cmd_op_out,
  output logic [FS_W-1:0] cmd_arg_out,
  output logic cmd_form_out
);
  initial begin
    cmd_valid_out = 1'b0;
    cmd_op_out = 4'h0;
    cmd_arg_out = '0;
    cmd_form_out = 1'b0;
  end
  // Integer arguments only, so five significant digits always suffice
  task automatic send(input logic [3:0] op, input logic [FS_W-1:0] arg, input logic form);
    @(posedge core_clk_in);
    cmd_valid_out <= 1'b1;
    cmd_op_out <= op;
    cmd_arg_out <= arg;
    cmd_form_out <= form;
  endtask
  task automatic done();
    @(posedge core_clk_in);
    cmd_valid_out <= 1'b0;
    // Idle argument lines never keep the last value
    cmd_arg_out <= ~cmd_arg_out;
    #1;
  endtask
  task automatic set(input logic [3:0] op, input logic [FS_W-1:0] arg, input logic form);
    send(prrc_pkg::CMD_UNLOCK, '0, 1'b0);
    send(op, arg, form);
    done();
  endtask
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic core_clk_in, rst_b_in, cmd_valid, cmd_form, rd_in, wdog, ss1, ss2, tick, sample, ss_en, err;
  logic [3:0] cmd_op, addr_in;
  logic [19:0] cmd_arg, factory_fs, fs_ref;
  logic [31:0] rdata;
  logic [4:0] unit;
  logic [7:0] low_level, high;
  int n_fail = 0;
  int checked = 0;
  prrc_top #(.FS_W(20), .STEP_CYC(10)) i_prrc_top (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_arg_in(cmd_arg), .cmd_form_in(cmd_form),
    .rd_in(rd_in), .addr_in(addr_in), .rdata_out(rdata), .factory_fs_in(factory_fs),
    .pressure_unit_select_in(unit), .low_level_in(low_level), .watchdog_output_option_in(wdog),
    .speed_shift_first_in(ss1), .speed_shift_second_in(ss2), .fs_ref_out(fs_ref),
    .high_level_out(high), .integ_tick_out(tick), .sample_out(sample),
    .speed_shift_en_out(ss_en), .command_error_flag_out(err));
  prrc_host #(.FS_W(20)) i_prrc_host (.core_clk_in(core_clk_in), .cmd_valid_out(cmd_valid),
    .cmd_op_out(cmd_op), .cmd_arg_out(cmd_arg), .cmd_form_out(cmd_form));
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // Third pulse gap, so a period cut short by reconfiguration is not measured
  task automatic gap(input bit s, input int exp);
    int n = 0;
    int p = 0;
    while (p < 3 && n < 400) begin
      @(posedge core_clk_in);
      #1;
      n++;
      if ((s ? sample : tick) === 1'b1) begin
        p++;
        if (p == 2) n = 0;
      end
    end
    chk(n, exp);
  endtask
  task automatic final_report();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_fail++;
    final_report();
  end
  initial begin
    {rst_b_in, rd_in, wdog, ss1, ss2} = 5'h00;
    addr_in = 4'h0;
    factory_fs = 20'h003E8;
    unit = 5'h03;
    low_level = 8'h14;
    repeat (8) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    rd(prrc_pkg::ADDR_INTEG, 32'h002);
    chk(fs_ref, 32'h003E8);
    $display("test defaults done");
    i_prrc_host.set(prrc_pkg::CMD_HIGH, 20'h00055, 1'b0);
    chk(high, 32'h55);
    rd(prrc_pkg::ADDR_HIGH, 32'h55);
    i_prrc_host.set(prrc_pkg::CMD_HIGH, 20'h00000, 1'b0);
    chk(high, 32'h64);
    i_prrc_host.set(prrc_pkg::CMD_HIGH, 20'h00055, 1'b0);
    i_prrc_host.set(prrc_pkg::CMD_HIGH, 20'h00096, 1'b0);
    chk(high, 32'h64);
    i_prrc_host.set(prrc_pkg::CMD_HIGH, 20'h00014, 1'b0);
    chk({err, high}, 32'h164);
    i_prrc_host.send(prrc_pkg::CMD_HIGH, 20'h00055, 1'b0);
    i_prrc_host.done();
    chk(high, 32'h64);
    i_prrc_host.set(prrc_pkg::CMD_CLRERR, 20'h00000, 1'b0);
    chk(err, 32'h0);
    $display("test high level done");
    i_prrc_host.set(prrc_pkg::CMD_FSCALE, 20'h001F3, 1'b0);
    chk({err, fs_ref}, 32'h1003E8);
    i_prrc_host.set(prrc_pkg::CMD_CLRERR, 20'h00000, 1'b0);
    i_prrc_host.set(prrc_pkg::CMD_FSCALE, 20'h003E9, 1'b0);
    chk({err, fs_ref}, 32'h1003E8);
    i_prrc_host.set(prrc_pkg::CMD_CLRERR, 20'h00000, 1'b0);
    i_prrc_host.set(prrc_pkg::CMD_FSCALE, 20'h001F4, 1'b0);
    chk({err, fs_ref}, 32'h0001F4);
    rd(prrc_pkg::ADDR_FSCALE, 32'h1F4);
    rd(prrc_pkg::ADDR_FSREF, 32'h1F4);
    unit <= 5'h04;
    rd(prrc_pkg::ADDR_FSUNIT, 32'h03);
    i_prrc_host.set(prrc_pkg::CMD_FSCALE, 20'h00000, 1'b0);
    chk(fs_ref, 32'h003E8);
    i_prrc_host.send(prrc_pkg::CMD_FSCALE, 20'h00200, 1'b0);
    i_prrc_host.done();
    chk(fs_ref, 32'h003E8);
    $display("test full scale done");
    i_prrc_host.set(prrc_pkg::CMD_INTEG, 20'h00079, 1'b1);
    chk(err, 32'h1);
    rd(prrc_pkg::ADDR_INTEG, 32'h002);
    i_prrc_host.set(prrc_pkg::CMD_CLRERR, 20'h00000, 1'b0);
    i_prrc_host.set(prrc_pkg::CMD_INTEG, 20'h00078, 1'b1);
    rd(prrc_pkg::ADDR_INTEG, 32'h178);
    i_prrc_host.set(prrc_pkg::CMD_SAVE, 20'h00000, 1'b0);
    i_prrc_host.set(prrc_pkg::CMD_INTEG, 20'h00001, 1'b0);
    gap(1'b0, 10);
    ss1 <= 1'b1;
    i_prrc_host.set(prrc_pkg::CMD_IDLE, 20'h00002, 1'b0);
    gap(1'b1, 30);
    chk(ss_en, 32'h1);
    i_prrc_host.set(prrc_pkg::CMD_INTEG, 20'h00000, 1'b0);
    rd(prrc_pkg::ADDR_INTEG, 32'h178);
    chk(ss_en, 32'h0);
    i_prrc_host.set(prrc_pkg::CMD_INTEG, 20'h00005, 1'b1);
    gap(1'b1, 20);
    rd(prrc_pkg::ADDR_TICKCFG, 32'h0);
    $display("test integration done");
    wdog <= 1'b1;
    i_prrc_host.set(prrc_pkg::CMD_IDLE, 20'h00003, 1'b0);
    chk(err, 32'h1);
    rd(prrc_pkg::ADDR_IDLE, 32'h02);
    rd(prrc_pkg::ADDR_STATUS, 32'h1);
    $display("test watchdog done");
    rst_b_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    rd(prrc_pkg::ADDR_INTEG, 32'h002);
    chk(fs_ref, 32'h003E8);
    $display("test reset done");
    final_report();
  end
endmodule
